/* hw/gpio_change_consts.vh */
// constants for the bidirectional port with change interrupt
`ifndef GPIO_CHANGE_CONSTS_VH
`define GPIO_CHANGE_CONSTS_VH

// register addresses
`define ADDR_PORT_DATA 4'h0
`define ADDR_PORT_DIR 4'h1
`define ADDR_OPTION 4'h2
`define ADDR_INT_CTRL 4'h3
`define ADDR_INT_STATUS 4'h4
`define ADDR_INT_MASK 4'h5

// field positions
`define OPT_PULLUP_DIS_N_BIT 7
`define ICR_GIE_BIT 7
`define ICR_CIE_BIT 3
`define ICR_CIF_BIT 0
`define STS_CHANGE_BIT 0
`define STS_WAKE_BIT 1
`define CHG_LO 4
`define CHG_HI 7

// reset values
`define RST_PORT_DATA 8'h00
`define RST_PORT_DIR 8'hFF
`define RST_OPTION 8'hFF
`define RST_INT_CTRL 8'h00
`define RST_ZERO 8'h00
`define RST_EVT 2'h0

`endif

/* hw/bidir_port_with_change_irq.v */
// bidirectional port with pull-ups, change detect, wake and interrupt
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_change_consts.vh"

module bidir_port_with_change_irq #(
    parameter WIDTH = 8
) (
    // clock, reset, enable
    input wire i_sys_clk,
    input wire i_srst,
    input wire i_clk_en,
    // register port
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // pins
    input wire [WIDTH-1:0] i_pin,
    output wire [WIDTH-1:0] o_pin,
    output wire [WIDTH-1:0] o_pin_oe,
    output wire [WIDTH-1:0] o_pullup_en,
    // device links
    input wire i_sleep,
    output wire o_wake,
    output wire o_change_irq,
    output wire o_irq
);

    // ----------------------------------------
    // local sizes
    // ----------------------------------------
    localparam CHG_W = `CHG_HI - `CHG_LO + 1;
    localparam EVT_W = 2;

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [WIDTH-1:0] port_latch_ff;
    reg [WIDTH-1:0] nxt_port_latch;
    reg [WIDTH-1:0] port_dir_ff;
    reg [WIDTH-1:0] nxt_port_dir;
    reg [7:0] option_ff;
    reg [7:0] nxt_option;
    reg [7:0] int_ctrl_ff;
    reg [7:0] nxt_int_ctrl;
    reg [CHG_W-1:0] cmp_latch_ff;
    reg [CHG_W-1:0] nxt_cmp_latch;
    reg [EVT_W-1:0] evt_sts_ff;
    wire [EVT_W-1:0] nxt_evt_sts;
    reg [EVT_W-1:0] evt_mask_ff;
    reg [EVT_W-1:0] nxt_evt_mask;
    reg [7:0] nxt_rdata;

    // ----------------------------------------
    // strobe qualification
    // ----------------------------------------
    // a strobe while frozen is dropped, not deferred
    wire wr_go = i_wr & i_clk_en;
    wire rd_go = i_rd & i_clk_en;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    reg sel_data;
    reg sel_dir;
    reg sel_opt;
    reg sel_ictl;
    reg sel_sts;
    reg sel_mask;

    always @* begin
        sel_data = 1'b0;
        sel_dir = 1'b0;
        sel_opt = 1'b0;
        sel_ictl = 1'b0;
        sel_sts = 1'b0;
        sel_mask = 1'b0;
        if (i_addr == `ADDR_PORT_DATA) begin
            sel_data = 1'b1;
        end else if (i_addr == `ADDR_PORT_DIR) begin
            sel_dir = 1'b1;
        end else if (i_addr == `ADDR_OPTION) begin
            sel_opt = 1'b1;
        end else if (i_addr == `ADDR_INT_CTRL) begin
            sel_ictl = 1'b1;
        end else if (i_addr == `ADDR_INT_STATUS) begin
            sel_sts = 1'b1;
        end else if (i_addr == `ADDR_INT_MASK) begin
            sel_mask = 1'b1;
        end
    end

    // ----------------------------------------
    // register strobes
    // ----------------------------------------
    wire port_rd = rd_go & sel_data;
    wire port_wr = wr_go & sel_data;
    wire dir_wr = wr_go & sel_dir;
    wire opt_wr = wr_go & sel_opt;
    wire ictl_wr = wr_go & sel_ictl;
    wire sts_wr = wr_go & sel_sts;
    wire mask_wr = wr_go & sel_mask;

    // ----------------------------------------
    // pin drivers and pull-ups
    // ----------------------------------------
    // output pins never pulled up
    wire pullup_on = ~option_ff[`OPT_PULLUP_DIS_N_BIT];
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : pin_gen
            assign o_pin_oe[g] = ~port_dir_ff[g];
            assign o_pin[g] = port_latch_ff[g];
            assign o_pullup_en[g] = pullup_on & port_dir_ff[g];
        end
    endgenerate

    // ----------------------------------------
    // change detect
    // ----------------------------------------
    wire [CHG_W-1:0] upper_change_pins = i_pin[`CHG_HI:`CHG_LO];
    wire [CHG_W-1:0] upper_inputs = port_dir_ff[`CHG_HI:`CHG_LO];
    wire [CHG_W-1:0] mismatch;
    genvar c;
    generate
        for (c = 0; c < CHG_W; c = c + 1) begin : chg_gen
            assign mismatch[c] = (upper_change_pins[c] ^ cmp_latch_ff[c]) & upper_inputs[c];
        end
    endgenerate
    // only inputs compare; a change seen in a refreshing read cycle still sets the flag
    wire change_cond = |mismatch;

    // ----------------------------------------
    // port data latch
    // ----------------------------------------
    wire [WIDTH-1:0] rmw_base = i_pin;
    // whole-byte write: the written byte replaces every bit read back
    wire [WIDTH-1:0] rmw_merge = (rmw_base & {WIDTH{1'b0}}) | i_wdata[WIDTH-1:0];

    always @* begin
        nxt_port_latch = port_latch_ff;
        if (port_wr) begin
            nxt_port_latch = rmw_merge;
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            port_latch_ff <= {WIDTH{1'b0}};
        end else begin
            if (i_clk_en) begin
                port_latch_ff <= nxt_port_latch;
            end
        end
    end

    // ----------------------------------------
    // direction register
    // ----------------------------------------
    always @* begin
        nxt_port_dir = port_dir_ff;
        if (dir_wr) begin
            nxt_port_dir = i_wdata[WIDTH-1:0];
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            port_dir_ff <= {WIDTH{1'b1}};
        end else begin
            if (i_clk_en) begin
                port_dir_ff <= nxt_port_dir;
            end
        end
    end

    // ----------------------------------------
    // option register
    // ----------------------------------------
    always @* begin
        nxt_option = option_ff;
        if (opt_wr) begin
            nxt_option = i_wdata;
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            option_ff <= `RST_OPTION;
        end else begin
            if (i_clk_en) begin
                option_ff <= nxt_option;
            end
        end
    end

    // ----------------------------------------
    // compare latch
    // ----------------------------------------
    always @* begin
        nxt_cmp_latch = cmp_latch_ff;
        // a write refreshes too, so no stale compare survives it
        if (port_rd || port_wr) begin
            nxt_cmp_latch = upper_change_pins;
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            cmp_latch_ff <= {CHG_W{1'b0}};
        end else begin
            if (i_clk_en) begin
                cmp_latch_ff <= nxt_cmp_latch;
            end
        end
    end

    // ----------------------------------------
    // interrupt control
    // ----------------------------------------
    always @* begin
        nxt_int_ctrl = int_ctrl_ff;
        if (ictl_wr) begin
            nxt_int_ctrl = i_wdata;
        end
        // set wins over a software clear in the same cycle
        if (change_cond) begin
            nxt_int_ctrl[`ICR_CIF_BIT] = 1'b1;
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            int_ctrl_ff <= `RST_INT_CTRL;
        end else begin
            if (i_clk_en) begin
                int_ctrl_ff <= nxt_int_ctrl;
            end
        end
    end

    // ----------------------------------------
    // wake and change interrupt
    // ----------------------------------------
    wire change_int_flag = int_ctrl_ff[`ICR_CIF_BIT];
    wire change_int_en = int_ctrl_ff[`ICR_CIE_BIT];
    wire global_int_enable = int_ctrl_ff[`ICR_GIE_BIT];

    assign o_change_irq = change_int_flag & change_int_en & global_int_enable;
    // wake ignores the global enable so a sleeping core still restarts
    assign o_wake = change_int_flag & change_int_en;

    // ----------------------------------------
    // event status
    // ----------------------------------------
    wire [EVT_W-1:0] evt_raise = {o_wake & i_sleep, change_cond};
    wire [EVT_W-1:0] evt_clear = sts_wr ? i_wdata[EVT_W-1:0] : {EVT_W{1'b0}};
    genvar e;
    generate
        for (e = 0; e < EVT_W; e = e + 1) begin : evt_gen
            // set wins over a write-one clear in the same cycle
            assign nxt_evt_sts[e] = (evt_sts_ff[e] & ~evt_clear[e]) | evt_raise[e];
        end
    endgenerate

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            evt_sts_ff <= `RST_EVT;
        end else begin
            if (i_clk_en) begin
                evt_sts_ff <= nxt_evt_sts;
            end
        end
    end

    // ----------------------------------------
    // event mask
    // ----------------------------------------
    always @* begin
        nxt_evt_mask = evt_mask_ff;
        if (mask_wr) begin
            nxt_evt_mask = i_wdata[EVT_W-1:0];
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            evt_mask_ff <= `RST_EVT;
        end else begin
            if (i_clk_en) begin
                evt_mask_ff <= nxt_evt_mask;
            end
        end
    end

    // ----------------------------------------
    // read views
    // ----------------------------------------
    // narrow registers read back zero in the unused bits
    wire [7:0] pin_view = i_pin;
    wire [7:0] dir_view = port_dir_ff;
    wire [7:0] opt_view = option_ff;
    wire [7:0] ictl_view = int_ctrl_ff;
    wire [7:0] sts_view = {6'h00, evt_sts_ff};
    wire [7:0] mask_view = {6'h00, evt_mask_ff};

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // read data hold between reads, so a late look sees the last answer
    always @* begin
        nxt_rdata = o_rdata;
        if (rd_go) begin
            if (sel_data) begin
                nxt_rdata = pin_view;
            end else if (sel_dir) begin
                nxt_rdata = dir_view;
            end else if (sel_opt) begin
                nxt_rdata = opt_view;
            end else if (sel_ictl) begin
                nxt_rdata = ictl_view;
            end else if (sel_sts) begin
                nxt_rdata = sts_view;
            end else if (sel_mask) begin
                nxt_rdata = mask_view;
            end else begin
                nxt_rdata = `RST_ZERO;
            end
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_rdata <= `RST_ZERO;
        end else begin
            if (i_clk_en) begin
                o_rdata <= nxt_rdata;
            end
        end
    end

    // ----------------------------------------
    // level interrupt
    // ----------------------------------------
    // level interrupt from sticky events
    assign o_irq = |(evt_sts_ff & evt_mask_ff);

endmodule
`default_nettype wire

/* test/keypad_pins.sv */
// keypad switches on the port pins
`timescale 1ns/10ps
`default_nettype none
module keypad_pins (
    input wire logic [7:0] i_key,
    input wire logic [7:0] i_pin,
    input wire logic [7:0] i_oe,
    output logic [7:0] o_lvl
);
    // driven pins show the latch, released pins the switch
    assign o_lvl = (i_oe & i_pin) | (~i_oe & i_key);
endmodule
`default_nettype wire

/* test/port_props.sv */
// assertion checker for the change-interrupt port
`timescale 1ns/10ps
`default_nettype none
module port_props (
    input wire logic i_sys_clk, i_srst, i_clk_en, i_wr, i_rd, i_sleep,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata, o_rdata, i_pin, o_pin, o_pin_oe, o_pullup_en,
    input wire logic o_wake, o_change_irq, o_irq
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    wire w_en = i_clk_en && i_wr;
    chk_dir_oe: assert property (w_en && i_addr == 4'h1 |=> o_pin_oe == ~$past(i_wdata))
        else $error("oe does not follow direction");
    chk_latch_wr: assert property (w_en && i_addr == 4'h0 |=> o_pin == $past(i_wdata))
        else $error("latch not written");
    chk_pin_read: assert property (i_clk_en && i_rd && i_addr == 4'h0 |=> o_rdata == $past(i_pin))
        else $error("port read not pin levels");
    chk_rdata_hold: assert property (!i_rd |=> $stable(o_rdata))
        else $error("read data moved");
    chk_pullup_out: assert property ((o_pullup_en & o_pin_oe) == 8'h00)
        else $error("pull-up on output pin");
    chk_pullup_rst: assert property ($fell(i_srst) |-> o_pullup_en == 8'h00)
        else $error("pull-up on after reset");
    chk_pullup_opt: assert property (w_en && i_addr == 4'h2 && i_wdata[7] |=> o_pullup_en == 8'h00)
        else $error("pull-up on while disabled");
    chk_irq_gate: assert property (o_change_irq |-> o_wake)
        else $error("irq without flag and enable");
    chk_wake_keep: assert property (o_wake && !(w_en && i_addr == 4'h3) |=> o_wake)
        else $error("flag lost without clear");
    cover property (o_change_irq);
    cover property (o_wake && i_sleep);
    cover property (o_irq);
endmodule
bind bidir_port_with_change_irq port_props u_props (.*);
`default_nettype wire

/* test/bidir_port_with_change_irq_bench.sv */
// self-checking bench for the change-interrupt port
`timescale 1ns/10ps
`default_nettype none
module bidir_port_with_change_irq_bench;
    logic i_sys_clk = 1'h0, i_srst = 1'h1, i_wr = 1'h0, i_rd = 1'h0, i_sleep = 1'h0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00, key = 8'hFF, lvl, o_rdata, o_pin, oe, pu, d, dv, o;
    wire o_wake, o_change_irq, o_irq;
    int n_fail = 0, n_tests = 0, seed = 32'hb2e9b976;
    always #12.5 i_sys_clk = ~i_sys_clk;
    keypad_pins pins (.i_key(key), .i_pin(o_pin), .i_oe(oe), .o_lvl(lvl));
    bidir_port_with_change_irq DUT (.*, .i_clk_en(1'h1), .i_pin(lvl), .o_pin_oe(oe),
        .o_pullup_en(pu));
    task automatic chk(input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= w;
        i_rd <= !w;
        @(posedge i_sys_clk);
        i_wr <= 1'h0;
        i_rd <= 1'h0;
        #1 o = o_rdata;
    endtask
    // bounded wait, a miss counts a failure and ends the run
    task automatic wait_wake;
        for (int k = 0; k < 8 && o_wake !== 1'h1; k++) @(posedge i_sys_clk);
        #1;
        if (o_wake !== 1'h1) begin
            n_fail++;
            $display("BAD %0t wake wait timed out", $time);
            wrap_up;
        end
    endtask
    task automatic wrap_up;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_srst <= 1'h0;
        #1 chk(pu, 8'h00);
        acc(1'h0, 4'h2, 8'h00);
        chk(o, 8'hFF);
        repeat (20) begin
            d = $random(seed);
            dv = $random(seed);
            key <= $random(seed);
            acc(1'h1, 4'h1, dv);
            acc(1'h1, 4'h0, d);
            acc(1'h1, 4'h2, {dv[0], 7'h00});
            chk(o_pin, d);
            chk(oe, ~dv);
            chk(pu, dv[0] ? 8'h00 : dv);
            acc(1'h0, 4'h0, 8'h00);
            chk(o, (d & ~dv) | (key & dv));
        end
        $display("random port access done");
        key <= 8'hFF;
        acc(1'h1, 4'h1, 8'h7F);
        acc(1'h1, 4'h3, 8'h00);
        acc(1'h1, 4'h5, 8'h01);
        acc(1'h0, 4'h0, 8'h00);
        key <= 8'h7E;
        acc(1'h1, 4'h3, 8'h08);
        repeat (4) @(posedge i_sys_clk);
        chk(o_wake, 1'h0);
        acc(1'h1, 4'h3, 8'h00);
        key <= 8'h5E;
        repeat (4) @(posedge i_sys_clk);
        acc(1'h0, 4'h3, 8'h00);
        chk(o & 8'h01, 8'h01);
        acc(1'h1, 4'h3, 8'h88);
        wait_wake;
        chk(o_change_irq, 1'h1);
        chk(o_irq, 1'h1);
        acc(1'h1, 4'h5, 8'h00);
        chk(o_irq, 1'h0);
        acc(1'h1, 4'h3, 8'h88);
        chk(o_change_irq, 1'h1);
        acc(1'h0, 4'h0, 8'h00);
        acc(1'h1, 4'h3, 8'h88);
        chk(o_change_irq, 1'h0);
        acc(1'h1, 4'h4, 8'h03);
        acc(1'h1, 4'h5, 8'h01);
        chk(o_irq, 1'h0);
        i_sleep <= 1'h1;
        acc(1'h1, 4'h3, 8'h08);
        key <= 8'h7E;
        wait_wake;
        chk(o_wake, 1'h1);
        chk(o_change_irq, 1'h0);
        acc(1'h0, 4'hF, 8'h00);
        chk(o, 8'h00);
        $display("change interrupt done");
        wrap_up;
    end
endmodule
`default_nettype wire
